/* bench/adc_power_management_control_tb.sv */
`timescale 1ns/1ps
`include "apmc_regs.svh"
module adc_power_management_control_tb
    import apmc_pkg::*;
;
    localparam int CYC = 20; // Short calibration and start-up waits
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [`APMC_ADDR_W-1:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] rdata;
    logic circuits_on, reference_on, calibrating, conv_done;
    int n_fail = 0;
    int check_count = 0;
    int n;
    logic [7:0] v;
    logic [7:0] exp_q[$];
    // Table of {pin, mode} and expected {circuits_on, reference_on}
    logic [2:0] tbl_mp [5] = '{3'h5, 3'h4, 3'h0, 3'h6, 3'h7};
    logic [1:0] tbl_pw [5] = '{2'h3, 2'h3, 2'h0, 2'h0, 2'h1};

    apmc_if u_apmc_if ();
    apmc_device #(.AUTOCAL_CYC(CYC), .SWCAL_CYC(CYC)) u_apmc_device (.clk(clk), .reset(reset),
        .link(u_apmc_if.dev), .circuits_on(circuits_on), .reference_on(reference_on),
        .calibrating(calibrating), .conv_done(conv_done));
    apmc_host #(.AUTOCAL_WAIT(CYC)) u_apmc_host (.clk(clk), .reset(reset), .link(u_apmc_if.host),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    apmc_sva #(.CAL_CYC(CYC)) u_apmc_sva (.clk(clk), .reset(reset),
        .sample_trigger_n(u_apmc_if.sample_trigger_n), .power_down_n(u_apmc_if.power_down_n),
        .cal_pin(u_apmc_if.cal_pin), .ctrl_wr(u_apmc_if.ctrl_wr), .ctrl_mode(u_apmc_if.ctrl_mode),
        .ctrl_cal(u_apmc_if.ctrl_cal), .ctrl_conv(u_apmc_if.ctrl_conv), .busy(u_apmc_if.busy),
        .circuits_on(circuits_on), .reference_on(reference_on), .calibrating(calibrating),
        .conv_done(conv_done));

    always #50 clk = ~clk;

    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One-cycle strobes; the gap cycle keeps each signal to one assignment per step
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        exp_q.push_back(e);
    endtask

    task apply(input logic [1:0] m, input logic p);
        wr_reg(`APMC_HOST_CTRL, {5'h00, p, m});
        wr_reg(`APMC_HOST_CMD, 8'h01);
        repeat (8) @(posedge clk);
    endtask

    // Bounded wait on busy (0), calibrating (1) or circuits_on (2)
    task wait_on(input int which, input logic lvl, input int lim);
        int k;
        logic s;
        k = 0;
        s = ~lvl;
        while (s !== lvl && k < lim) begin
            @(negedge clk);
            s = (which == 0) ? u_apmc_if.busy : (which == 1) ? calibrating : circuits_on;
            k++;
        end
        if (s !== lvl) begin
            n_fail++;
            $display("BAD %0t wait ran out", $time);
        end
    endtask

    task do_reset;
        reset <= 1'b1;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d) begin
            check(rdata, exp_q.pop_front());
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        $display("BAD %0t watchdog", $time);
        report_and_stop;
    end

    initial begin
        v = 8'($urandom(32'h02EB3C00));
        do_reset;
        // Pin is low during autocal, yet power must stay up
        wait_on(1, 1'b1, 3);
        check({7'h00, circuits_on}, 8'h01);
        wait_on(1, 1'b0, CYC + 5);
        repeat (3) @(negedge clk);
        check({6'h00, circuits_on, reference_on}, 8'h00);
        repeat (CYC) @(posedge clk);
        rd_reg(`APMC_HOST_CTRL, 8'h00);
        rd_reg(4'hC, 8'h00);
        rd_reg(`APMC_HOST_CMD, 8'h00);
        rd_reg(`APMC_HOST_STAT, 8'h01);
        // Every mode code, each entered from normal operation
        for (int i = 0; i < 5; i++) begin
            apply(2'h1, 1'b1);
            apply(tbl_mp[i][1:0], tbl_mp[i][2]);
            @(negedge clk);
            check({6'h00, circuits_on, reference_on}, {6'h00, tbl_pw[i]});
        end
        // Trigger wakes from full power-down, which returns at the end
        apply(2'h0, 1'b0);
        wr_reg(`APMC_HOST_CMD, 8'h08);
        wait_on(2, 1'b1, 5);
        wait_on(0, 1'b1, 70);
        n = 0;
        while (u_apmc_if.busy === 1'b1 && n < 100) begin
            n++;
            @(negedge clk);
        end
        check(n[7:0], 8'h2E);
        check({6'h00, circuits_on, reference_on}, 8'h00);
        // Forced full power-down ignores the trigger
        apply(2'h2, 1'b1);
        wr_reg(`APMC_HOST_CMD, 8'h08);
        repeat (70) @(negedge clk);
        check({6'h00, circuits_on, u_apmc_if.busy}, 8'h00);
        // Pin high: conversion leaves power on
        apply(2'h0, 1'b1);
        wr_reg(`APMC_HOST_CMD, 8'h04);
        wait_on(0, 1'b1, 10);
        rd_reg(`APMC_HOST_STAT, 8'h03);
        wait_on(0, 1'b0, 60);
        @(negedge clk);
        check({7'h00, circuits_on}, 8'h01);
        // Calibration in partial mode does not end in partial power-down
        apply(2'h3, 1'b1);
        wr_reg(`APMC_HOST_CMD, 8'h02);
        wait_on(1, 1'b1, 10);
        wait_on(1, 1'b0, CYC + 10);
        @(negedge clk);
        check({6'h00, circuits_on, reference_on}, 8'h03);
        // Random control values round-trip through the register port
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom_range(15));
            wr_reg(`APMC_HOST_CTRL, v);
            rd_reg(`APMC_HOST_CTRL, v);
        end
        // Second reset in mid-run clears the mode bits and recalibrates
        do_reset;
        rd_reg(`APMC_HOST_CTRL, 8'h00);
        wait_on(1, 1'b1, 3);
        // Raising the calibration pin ends power-on calibration well before its length
        wr_reg(`APMC_HOST_CTRL, 8'h0C);
        wait_on(1, 1'b0, 6);
        @(negedge clk);
        check({7'h00, circuits_on}, 8'h01);
        repeat (4) @(posedge clk);
        report_and_stop;
    end
endmodule

/* bench/apmc_sva.sv */
`timescale 1ns/1ps
module apmc_sva #(
    parameter int CAL_CYC = 20 // Calibration length in cycles
) (
    input wire logic clk, // Master clock
    input wire logic reset, // Synchronous reset, active high
    input wire logic sample_trigger_n, // Conversion-start pin
    input wire logic power_down_n, // Hardware power-down pin
    input wire logic cal_pin, // Skip-autocal pin
    input wire logic ctrl_wr, // Control write strobe
    input wire logic [1:0] ctrl_mode, // Power-mode bits
    input wire logic ctrl_cal, // Calibration request
    input wire logic ctrl_conv, // Conversion request
    input wire logic busy, // Conversion in progress
    input wire logic circuits_on, // Converter powered
    input wire logic reference_on, // Reference powered
    input wire logic calibrating, // Calibration running
    input wire logic conv_done // End-of-conversion pulse
);
    logic [1:0] mode_r, mode_nxt;
    logic [7:0] busy_cnt_r, busy_cnt_nxt;
    logic [19:0] cal_cnt_r, cal_cnt_nxt;

    // Shadow of the stored mode bits and run lengths of busy and calibrating
    always_comb begin
        mode_nxt = ctrl_wr ? ctrl_mode : mode_r;
        busy_cnt_nxt = busy ? busy_cnt_r + 8'h01 : 8'h00;
        cal_cnt_nxt = calibrating ? cal_cnt_r + 20'h00001 : 20'h00000;
    end

    // Shadow clears with reset, as the mode bits do
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= 2'h0;
            busy_cnt_r <= 8'h00;
            cal_cnt_r <= 20'h00000;
        end else begin
            mode_r <= mode_nxt;
            busy_cnt_r <= busy_cnt_nxt;
            cal_cnt_r <= cal_cnt_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_busy_length: assert property (!busy && $past(busy) |-> busy_cnt_r == 8'h2E)
        else $error("conversion length wrong");
    a_done_with_fall: assert property ((conv_done || $fell(busy)) |-> (conv_done && $fell(busy)))
        else $error("done pulse not at busy fall");
    a_auto_down: assert property ($fell(busy) && mode_r == 2'h0 && !power_down_n
        && !$past(power_down_n) && !$past(ctrl_wr) |-> !circuits_on && !reference_on)
        else $error("no full power-down after conversion");
    a_fall_cause: assert property ($fell(circuits_on) |-> mode_r != 2'h1
        && !(mode_r == 2'h0 && $past(power_down_n) && $past(power_down_n, 2)))
        else $error("power-down in a normal mode");
    a_ref_only_full: assert property (!reference_on |-> !circuits_on && !busy && !calibrating)
        else $error("reference off while circuits on");
    a_cal_powered: assert property (calibrating || busy |-> circuits_on && reference_on)
        else $error("powered down while busy or calibrating");
    a_cal_length: assert property (!calibrating && $past(calibrating) && !$past(cal_pin)
        |-> cal_cnt_r == 20'(CAL_CYC))
        else $error("calibration length wrong");
    a_autocal_start: assert property ($fell(reset) && !cal_pin |-> ##[0:2] calibrating)
        else $error("no calibration after reset");
    a_wake_time: assert property ($fell(sample_trigger_n) && !circuits_on && mode_r != 2'h2
        |=> circuits_on && !busy ##1 !busy [*7] ##[40:60] busy)
        else $error("wake timing wrong");
    a_no_auto_partial: assert property ($fell(calibrating) && mode_r != 2'h0 && mode_r != 2'h2
        |-> circuits_on)
        else $error("partial power-down after calibration");
    a_reset_state: assert property ($fell(reset) |-> circuits_on && reference_on && !busy)
        else $error("wrong state after reset");

    // Main scenarios reached
    c_conv_done: cover property (conv_done);
    c_partial: cover property (!circuits_on && reference_on);
    c_cal_cmd: cover property (ctrl_wr && ctrl_cal);
    c_conv_cmd: cover property (ctrl_wr && ctrl_conv);
endmodule

/* inc/apmc_if.sv */
`timescale 1ns/1ps
interface apmc_if;
    logic sample_trigger_n; // Conversion-start pin, falling wakes, rising converts
    logic power_down_n;     // Hardware power-down pin, low requests power-down
    logic cal_pin;          // Calibration pin, high at power-on skips autocal
    logic ctrl_wr;          // Control register write strobe
    logic [1:0] ctrl_mode;  // power_mode_hi_bit, power_mode_lo_bit
    logic ctrl_cal;         // Start software calibration
    logic ctrl_conv;        // Start software conversion
    logic busy;             // Conversion in progress

    modport dev (input sample_trigger_n, power_down_n, cal_pin, ctrl_wr, ctrl_mode,
                 ctrl_cal, ctrl_conv, output busy);
    modport host (output sample_trigger_n, power_down_n, cal_pin, ctrl_wr, ctrl_mode,
                  ctrl_cal, ctrl_conv, input busy);
endinterface

/* inc/apmc_pkg.sv */
package apmc_pkg;
    typedef enum logic [2:0] {
        ST_POR, ST_AUTOCAL, ST_NORMAL, ST_CONVERT, ST_CAL, ST_FULL_DOWN, ST_PARTIAL, ST_WAKE
    } apmc_dev_state_t;

    typedef enum logic [1:0] {
        H_WAIT, H_IDLE, H_SEQ, H_TRIG
    } apmc_host_state_t;

    typedef enum logic [1:0] {
        K_APPLY, K_CONV, K_CAL, K_CAL_PARTIAL
    } apmc_seq_kind_t;
endpackage

/* inc/apmc_regs.svh */
`ifndef APMC_REGS_SVH
`define APMC_REGS_SVH

// Power-mode codes carried by the two power-mode bits
`define APMC_MODE_PIN 2'h0
`define APMC_MODE_NORMAL 2'h1
`define APMC_MODE_FULL 2'h2
`define APMC_MODE_PARTIAL 2'h3

// Clock rate and documented times
`define APMC_CLK_MHZ 10
`define APMC_WAKE_NS 5000
`define APMC_CONV_NS 4600
`define APMC_TRIG_LOW_NS 5000
`define APMC_PWRON_US 300
`define APMC_AUTOCAL_US 32000
`define APMC_SWCAL_US 31250

// Cycle counts derived from the times above (least times round up)
`define APMC_WAKE_CYC ((`APMC_WAKE_NS * `APMC_CLK_MHZ + 999) / 1000)
`define APMC_CONV_CYC ((`APMC_CONV_NS * `APMC_CLK_MHZ + 999) / 1000)
`define APMC_TRIG_LOW_CYC ((`APMC_TRIG_LOW_NS * `APMC_CLK_MHZ + 999) / 1000)
`define APMC_PWRON_CYC (`APMC_PWRON_US * `APMC_CLK_MHZ)
`define APMC_AUTOCAL_CYC (`APMC_AUTOCAL_US * `APMC_CLK_MHZ)
`define APMC_SWCAL_CYC (`APMC_SWCAL_US * `APMC_CLK_MHZ)
`define APMC_CNT_W 19

// Host register map (byte addresses) and field positions
`define APMC_ADDR_W 4
`define APMC_HOST_CTRL 4'h0
`define APMC_HOST_CMD 4'h4
`define APMC_HOST_STAT 4'h8
`define APMC_CTRL_MODE_LO 0
`define APMC_CTRL_MODE_HI 1
`define APMC_CTRL_PIN 2
`define APMC_CTRL_SKIPCAL 3
`define APMC_CMD_APPLY 0
`define APMC_CMD_CAL 1
`define APMC_CMD_CONV 2
`define APMC_CMD_TRIG 3
`define APMC_STAT_READY 0
`define APMC_STAT_BUSY 1
`define APMC_STAT_ACTIVE 2
`define APMC_CTRL_RESET 4'h0

`endif

/* logic/apmc_device.sv */
`timescale 1ns/1ps
`include "apmc_regs.svh"

// Behaviour
// - Bits 00, pin low: full down when idle
// - Bits 00, pin high: always normal operation
// - Full power-down switches off all circuitry
// - Bits 11: partial down, reference stays on
// - Pin control: host keeps mode bits zero
// - Software control: host holds pin high
// - Low throughput: host ties pin low
// - Auto full power-down when busy falls
// - Trigger falling edge wakes, ready in 5 us
// - Host holds trigger low at least 5 us
// - Pin ignored until power-on calibration ends
// - Calibration pin high skips power-on calibration
// - Host idles 32 ms during autocalibration
// - No autocal: host waits power-up time first
// - Host writes normal mode before software conversion
// - No automatic partial power-down after calibration
// - Partial-mode calibration takes three host writes
module apmc_device
    import apmc_pkg::*;
#(
    parameter int AUTOCAL_CYC = `APMC_AUTOCAL_CYC, // Power-on calibration length
    parameter int SWCAL_CYC = `APMC_SWCAL_CYC      // Software calibration length
) (
    input wire logic clk,           // Master clock
    input wire logic reset,         // Synchronous reset, active high
    apmc_if.dev link,               // Pins and control register from host
    output logic circuits_on,       // Converter circuitry powered
    output logic reference_on,      // Reference powered
    output logic calibrating,       // Calibration in progress
    output logic conv_done          // One-cycle pulse at end of conversion
);

    localparam logic [`APMC_CNT_W-1:0] WAKE_LOAD = `APMC_CNT_W'(`APMC_WAKE_CYC - 1);
    localparam logic [`APMC_CNT_W-1:0] CONV_LOAD = `APMC_CNT_W'(`APMC_CONV_CYC - 1);
    localparam logic [`APMC_CNT_W-1:0] AUTOCAL_LOAD = `APMC_CNT_W'(AUTOCAL_CYC - 1);
    localparam logic [`APMC_CNT_W-1:0] SWCAL_LOAD = `APMC_CNT_W'(SWCAL_CYC - 1);

    apmc_dev_state_t state_r, state_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic arm_r, arm_nxt;
    logic [`APMC_CNT_W-1:0] cnt_r, cnt_nxt;
    logic trig_q_r, trig_q_nxt;
    logic pend_r, pend_nxt;
    logic busy_r, busy_nxt;
    logic circuits_nxt, reference_nxt, calibrating_nxt, conv_done_nxt;
    logic trig_fall, trig_rise, cnt_zero;

    // Idle power state chosen from mode bits, pin and partial arming
    function automatic apmc_dev_state_t idle_state(input logic [1:0] mode, input logic pin_n,
                                                   input logic arm);
        apmc_dev_state_t s;
        s = ST_NORMAL;
        unique case (mode)
            `APMC_MODE_PIN: s = pin_n ? ST_NORMAL : ST_FULL_DOWN;
            `APMC_MODE_NORMAL: s = ST_NORMAL;
            `APMC_MODE_FULL: s = ST_FULL_DOWN;
            `APMC_MODE_PARTIAL: s = arm ? ST_PARTIAL : ST_NORMAL;
        endcase
        return s;
    endfunction

    // Pins come from host logic on this same clock, so no synchroniser
    assign trig_fall = trig_q_r & ~link.sample_trigger_n;
    assign trig_rise = ~trig_q_r & link.sample_trigger_n;
    assign cnt_zero = (cnt_r == '0);

    // Power sequencer next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_zero ? cnt_r : cnt_r - 1'b1;
        mode_nxt = link.ctrl_wr ? link.ctrl_mode : mode_r;
        arm_nxt = arm_r;
        pend_nxt = pend_r;
        trig_q_nxt = link.sample_trigger_n;
        conv_done_nxt = 1'b0;
        // Partial power-down is armed only by an explicit write of mode 11
        if (link.ctrl_wr && link.ctrl_mode == `APMC_MODE_PARTIAL) begin
            arm_nxt = 1'b1;
        end
        unique case (state_r)
            ST_POR: begin
                // Calibration pin caught one clock after reset release
                if (link.cal_pin) begin
                    state_nxt = idle_state(mode_nxt, link.power_down_n, arm_nxt);
                end else begin
                    state_nxt = ST_AUTOCAL;
                    cnt_nxt = AUTOCAL_LOAD;
                end
            end
            ST_AUTOCAL: begin
                // Power-down pin is not looked at until this ends; the host can only
                // raise the calibration pin after reset, so a high level cuts it short
                if (cnt_zero || link.cal_pin) begin
                    state_nxt = idle_state(mode_nxt, link.power_down_n, arm_nxt);
                end
            end
            ST_NORMAL, ST_FULL_DOWN, ST_PARTIAL: begin
                if (link.ctrl_wr && link.ctrl_cal) begin
                    state_nxt = ST_CAL;
                    cnt_nxt = SWCAL_LOAD;
                end else if (state_r == ST_NORMAL &&
                             (trig_rise || (link.ctrl_wr && link.ctrl_conv))) begin
                    state_nxt = ST_CONVERT;
                    cnt_nxt = CONV_LOAD;
                end else if (state_r != ST_NORMAL && trig_fall &&
                             mode_r != `APMC_MODE_FULL) begin
                    // Software full power-down needs a mode write, not a pulse
                    state_nxt = ST_WAKE;
                    cnt_nxt = WAKE_LOAD;
                    pend_nxt = 1'b0;
                end else begin
                    state_nxt = idle_state(mode_nxt, link.power_down_n, arm_nxt);
                end
            end
            ST_WAKE: begin
                // An early rising edge is held and served once powered up
                if (trig_rise) begin
                    pend_nxt = 1'b1;
                end
                if (cnt_zero && (pend_r || trig_rise)) begin
                    state_nxt = ST_CONVERT;
                    cnt_nxt = CONV_LOAD;
                    pend_nxt = 1'b0;
                end
            end
            ST_CONVERT: begin
                if (cnt_zero) begin
                    // Decision taken as busy falls
                    conv_done_nxt = 1'b1;
                    state_nxt = idle_state(mode_nxt, link.power_down_n, arm_nxt);
                end
            end
            ST_CAL: begin
                if (cnt_zero) begin
                    arm_nxt = link.ctrl_wr && link.ctrl_mode == `APMC_MODE_PARTIAL;
                    state_nxt = idle_state(mode_nxt, link.power_down_n, arm_nxt);
                end
            end
        endcase
        busy_nxt = (state_nxt == ST_CONVERT);
        circuits_nxt = !(state_nxt == ST_FULL_DOWN || state_nxt == ST_PARTIAL);
        reference_nxt = (state_nxt != ST_FULL_DOWN);
        calibrating_nxt = (state_nxt == ST_CAL || state_nxt == ST_AUTOCAL);
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= ST_POR;
            mode_r <= `APMC_MODE_PIN;
            arm_r <= 1'b0;
            cnt_r <= '0;
            trig_q_r <= 1'b1;
            pend_r <= 1'b0;
            busy_r <= 1'b0;
            circuits_on <= 1'b1;
            reference_on <= 1'b1;
            calibrating <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            arm_r <= arm_nxt;
            cnt_r <= cnt_nxt;
            trig_q_r <= trig_q_nxt;
            pend_r <= pend_nxt;
            busy_r <= busy_nxt;
            circuits_on <= circuits_nxt;
            reference_on <= reference_nxt;
            calibrating <= calibrating_nxt;
            conv_done <= conv_done_nxt;
        end
    end

    assign link.busy = busy_r;

endmodule

/* logic/apmc_host.sv */
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "apmc_regs.svh"

module apmc_host
    import apmc_pkg::*;
#(
    parameter int AUTOCAL_WAIT = `APMC_AUTOCAL_CYC // Idle time after reset with autocal
) (
    input wire logic clk,                        // Master clock
    input wire logic reset,                      // Synchronous reset, active high
    apmc_if.host link,                           // Pins and control register of device
    input wire logic [`APMC_ADDR_W-1:0] addr,    // Register byte address
    input wire logic [7:0] wdata,                // Write data
    input wire logic wr,                         // Write strobe
    input wire logic rd,                         // Read strobe
    output logic [7:0] rdata                     // Read data, cycle after rd
);

    localparam logic [`APMC_CNT_W-1:0] WAIT_CAL = `APMC_CNT_W'(AUTOCAL_WAIT - 1);
    localparam logic [`APMC_CNT_W-1:0] WAIT_PWR = `APMC_CNT_W'(`APMC_PWRON_CYC - 1);
    localparam logic [`APMC_CNT_W-1:0] TRIG_LOAD = `APMC_CNT_W'(`APMC_TRIG_LOW_CYC - 1);

    apmc_host_state_t state_r, state_nxt;
    apmc_seq_kind_t kind_r, kind_nxt;
    logic [1:0] step_r, step_nxt;
    logic [3:0] ctrl_r, ctrl_nxt;
    logic [`APMC_CNT_W-1:0] cnt_r, cnt_nxt;
    logic trig_n_r, trig_n_nxt, pin_r, pin_nxt, cal_r, cal_nxt;
    logic wr_r, wr_nxt, wcal_r, wcal_nxt, wconv_r, wconv_nxt;
    logic [1:0] wmode_r, wmode_nxt;
    logic [7:0] rdata_nxt;
    logic [1:0] mode;
    logic cmd_wr, last;

    assign mode = ctrl_r[`APMC_CTRL_MODE_HI:`APMC_CTRL_MODE_LO];
    assign cmd_wr = wr && addr == `APMC_HOST_CMD;

    // Command sequencer and pin drivers
    always_comb begin
        state_nxt = state_r;
        kind_nxt = kind_r;
        step_nxt = step_r;
        ctrl_nxt = (wr && addr == `APMC_HOST_CTRL) ? wdata[3:0] : ctrl_r;
        cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
        trig_n_nxt = trig_n_r;
        wr_nxt = 1'b0;
        wmode_nxt = mode;
        wcal_nxt = 1'b0;
        wconv_nxt = 1'b0;
        last = 1'b1;
        // Software control keeps the pin high; pin control uses mode 00
        pin_nxt = (mode != `APMC_MODE_PIN) ? 1'b1 : ctrl_r[`APMC_CTRL_PIN];
        cal_nxt = ctrl_r[`APMC_CTRL_SKIPCAL];
        unique case (state_r)
            H_WAIT: begin
                if (cnt_r == '0) begin
                    state_nxt = H_IDLE;
                end
            end
            H_IDLE: begin
                if (cmd_wr && wdata[`APMC_CMD_TRIG]) begin
                    state_nxt = H_TRIG;
                    trig_n_nxt = 1'b0;
                    cnt_nxt = TRIG_LOAD;
                end else if (cmd_wr && (wdata[`APMC_CMD_CAL] || wdata[`APMC_CMD_CONV] ||
                                        wdata[`APMC_CMD_APPLY])) begin
                    state_nxt = H_SEQ;
                    step_nxt = 2'h0;
                    if (wdata[`APMC_CMD_CAL]) begin
                        kind_nxt = (mode == `APMC_MODE_PARTIAL) ? K_CAL_PARTIAL : K_CAL;
                    end else if (wdata[`APMC_CMD_CONV]) begin
                        kind_nxt = K_CONV;
                    end else begin
                        kind_nxt = K_APPLY;
                    end
                end
            end
            H_SEQ: begin
                wr_nxt = 1'b1;
                unique case (kind_r)
                    K_APPLY: begin
                        last = 1'b1;
                    end
                    K_CAL: begin
                        wcal_nxt = 1'b1;
                    end
                    K_CONV: begin
                        // Separate power-up write, then the starting write
                        wmode_nxt = `APMC_MODE_NORMAL;
                        wconv_nxt = (step_r == 2'h1);
                        last = (step_r == 2'h1);
                    end
                    K_CAL_PARTIAL: begin
                        // Power up, start calibration, then select partial
                        wmode_nxt = (step_r == 2'h2) ? `APMC_MODE_PARTIAL : `APMC_MODE_NORMAL;
                        wcal_nxt = (step_r == 2'h1);
                        last = (step_r == 2'h2);
                    end
                endcase
                step_nxt = step_r + 2'h1;
                if (last) begin
                    state_nxt = H_IDLE;
                end
            end
            H_TRIG: begin
                // Low phase covers the device wake-up time
                if (cnt_r == '0) begin
                    trig_n_nxt = 1'b1;
                    state_nxt = H_IDLE;
                end
            end
        endcase
        unique case (addr)
            `APMC_HOST_CTRL: rdata_nxt = {4'h0, ctrl_r};
            `APMC_HOST_STAT: rdata_nxt = {5'h00, state_r != H_IDLE && state_r != H_WAIT,
                                          link.busy, state_r != H_WAIT};
            default: rdata_nxt = 8'h00;
        endcase
        if (!rd) begin
            rdata_nxt = 8'h00;
        end
    end

    // Host registers; mode bits and pins start at their reset values
    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= H_WAIT;
            kind_r <= K_APPLY;
            step_r <= 2'h0;
            ctrl_r <= `APMC_CTRL_RESET;
            cnt_r <= WAIT_CAL;
            trig_n_r <= 1'b1;
            pin_r <= 1'b0;
            cal_r <= 1'b0;
            wr_r <= 1'b0;
            wmode_r <= `APMC_MODE_PIN;
            wcal_r <= 1'b0;
            wconv_r <= 1'b0;
            rdata <= 8'h00;
        end else begin
            state_r <= state_nxt;
            kind_r <= kind_nxt;
            step_r <= step_nxt;
            ctrl_r <= ctrl_nxt;
            // Skipping autocal shortens the start-up wait to the power-up time
            if (state_r == H_WAIT && wr && addr == `APMC_HOST_CTRL &&
                wdata[`APMC_CTRL_SKIPCAL] && cnt_r > WAIT_PWR) begin
                cnt_r <= WAIT_PWR;
            end else begin
                cnt_r <= cnt_nxt;
            end
            trig_n_r <= trig_n_nxt;
            pin_r <= pin_nxt;
            cal_r <= cal_nxt;
            wr_r <= wr_nxt;
            wmode_r <= wmode_nxt;
            wcal_r <= wcal_nxt;
            wconv_r <= wconv_nxt;
            rdata <= rdata_nxt;
        end
    end

    assign link.sample_trigger_n = trig_n_r;
    assign link.power_down_n = pin_r;
    assign link.cal_pin = cal_r;
    assign link.ctrl_wr = wr_r;
    assign link.ctrl_mode = wmode_r;
    assign link.ctrl_cal = wcal_r;
    assign link.ctrl_conv = wconv_r;

endmodule
